// ---- verilog/pewc_consts.vh ----
// Behaviour
// - Delay enable set: hold power-event output until clocks are ready for host access.
// - Delay enable honoured only while automatic wake-up enable is set.
// - Polarity bit one drives output active high, zero active low.
// - Bits 11..8 enable wake frame, wake packet, link up, energy onto output.
// - Auto wake-up in energy detect wakes after energy persists past wake-up time.
// - Bit 6 set: energy wake-up leaves energy detect for normal mode; host-access wake and bit 6 clear stay.
// - Bits 5..2 report the wake cause: frame, packet, link up, energy.
// - Energy wake sets interrupt status bit 2; link-up wake sets bit 3.
// - Output asserts while any flag is set with its enable set.
// - Flags clear on power-up reset or write one; other resets keep them.
// - Clearing the flags deasserts the power-event output.
// - Mode field bits 1..0: 00 normal, 01 energy detect, 11 saving; reset 00.
// - Energy detect low-power state wakes on line energy or any register access.
// - Normal-power state keeps reception and transmission available.
// - Wake-up time counts 16 ms units, default 8, zero not allowed; the code takes zero as one unit.
// - Low-power entry after no energy for go-sleep time, 1 s units, default 12.
`ifndef PEWC_CONSTS_VH
`define PEWC_CONSTS_VH
`define PEWC_OFS_CTRL 8'hD4
`define PEWC_OFS_TIME 8'hD6
`define PEWC_BIT_DLY 14
`define PEWC_BIT_POL 12
`define PEWC_EN_HI 11
`define PEWC_EN_LO 8
`define PEWC_BIT_AUTO 7
`define PEWC_BIT_TONORM 6
`define PEWC_EVT_HI 5
`define PEWC_EVT_LO 2
`define PEWC_MODE_NORMAL 2'h0
`define PEWC_MODE_EDET 2'h1
`define PEWC_MODE_SAVE 2'h3
`define PEWC_CTRL_WMASK 16'h5FC3
`define PEWC_WAKE_DEF 8'h08
`define PEWC_SLEEP_DEF 8'h0C
`define PEWC_WAKE_UNIT_US 16000
`define PEWC_SLEEP_UNIT_US 1000000
`define PEWC_CLK_MHZ 10
`define PEWC_ISR_ENERGY 2
`define PEWC_ISR_LINK 3
`endif

// ---- verilog/pewc_tick.v ----
`timescale 1ns/10ps
`include "pewc_consts.vh"
// unit tick generator and unit counter
module pewc_tick #(
  parameter UNIT_CYC = 160000
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // control
  input wire run,
  input wire [7:0] limit,
  // status
  output reg done_q
);
  reg [31:0] cyc_q;
  reg [7:0] units_q;
  wire unit_end = (cyc_q == UNIT_CYC - 1);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cyc_q <= 32'h0;
      units_q <= 8'h0;
      done_q <= 1'b0;
    end else if (!run) begin
      cyc_q <= 32'h0;
      units_q <= 8'h0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      cyc_q <= unit_end ? 32'h0 : cyc_q + 32'h1;
      if (unit_end) begin
        units_q <= units_q + 8'h1;
        // zero limit treated as one unit
        if (units_q + 8'h1 >= limit || limit == 8'h0)
          done_q <= 1'b1;
      end
    end
  end
endmodule // pewc_tick

// ---- verilog/pewc_top.v ----
`timescale 1ns/10ps
`include "pewc_consts.vh"
module pewc_top #(
  parameter WAKE_UNIT_CYC = `PEWC_WAKE_UNIT_US * `PEWC_CLK_MHZ,
  parameter SLEEP_UNIT_CYC = `PEWC_SLEEP_UNIT_US * `PEWC_CLK_MHZ
) (
  // clock and resets
  input wire mclk,
  input wire resetn,
  input wire por_n,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_q,
  // line-side events
  input wire line_energy,
  input wire evt_link_up,
  input wire evt_wake_packet,
  input wire evt_wake_frame,
  input wire clocks_ready,
  // outputs
  output reg power_event_output_q,
  output reg [1:0] mode_q,
  output reg low_power_q,
  output reg traffic_en_q,
  output reg isr_energy_set_q,
  output reg isr_link_set_q
);
  localparam ST_NORM = 2'b01;
  localparam ST_LOW = 2'b10;
  reg [15:0] ctrl_q;
  reg [15:0] time_q;
  reg [3:0] flags_q;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [1:0] mode_d;
  wire wr_ctrl = reg_wr && reg_addr == `PEWC_OFS_CTRL;
  wire wr_time = reg_wr && reg_addr == `PEWC_OFS_TIME;
  wire edet = ctrl_q[1:0] == `PEWC_MODE_EDET;
  wire auto_wk = ctrl_q[`PEWC_BIT_AUTO];
  wire wake_done;
  wire sleep_done;
  pewc_tick #(.UNIT_CYC(WAKE_UNIT_CYC)) u_wake (
    .mclk(mclk), .resetn(resetn),
    .run(edet && st_q == ST_LOW && line_energy),
    .limit(time_q[15:8]), .done_q(wake_done));
  pewc_tick #(.UNIT_CYC(SLEEP_UNIT_CYC)) u_sleep (
    .mclk(mclk), .resetn(resetn),
    .run(edet && st_q == ST_NORM && !line_energy),
    .limit(time_q[7:0]), .done_q(sleep_done));
  wire energy_wake = edet && st_q == ST_LOW && auto_wk && wake_done;
  wire host_wake = edet && st_q == ST_LOW && (reg_wr || reg_rd);
  wire [3:0] evt_in = {evt_wake_frame, evt_wake_packet, evt_link_up, energy_wake};
  wire [3:0] flags_d = (flags_q & ~(wr_ctrl ? reg_wdata[`PEWC_EVT_HI:`PEWC_EVT_LO] : 4'h0))
                       | evt_in;
  wire pme_hit = |(flags_q & ctrl_q[`PEWC_EN_HI:`PEWC_EN_LO]);
  wire hold = ctrl_q[`PEWC_BIT_DLY] && auto_wk && !clocks_ready;
  // power-up reset only for flags
  always @(posedge mclk or negedge por_n) begin
    if (!por_n)
      flags_q <= 4'h0;
    else
      flags_q <= flags_d;
  end
  always @* begin
    st_d = st_q;
    mode_d = ctrl_q[1:0];
    case (st_q)
      ST_NORM: begin
        if (edet && sleep_done)
          st_d = ST_LOW;
      end
      ST_LOW: begin
        if (!edet || host_wake || energy_wake)
          st_d = ST_NORM;
        if (energy_wake && ctrl_q[`PEWC_BIT_TONORM])
          mode_d = `PEWC_MODE_NORMAL;
      end
      default: st_d = ST_NORM;
    endcase
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 16'h0000;
      time_q <= {`PEWC_WAKE_DEF, `PEWC_SLEEP_DEF};
      st_q <= ST_NORM;
      reg_rdata_q <= 16'h0000;
      power_event_output_q <= 1'b1;
      mode_q <= `PEWC_MODE_NORMAL;
      low_power_q <= 1'b0;
      traffic_en_q <= 1'b1;
      isr_energy_set_q <= 1'b0;
      isr_link_set_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (wr_ctrl)
        ctrl_q <= reg_wdata & `PEWC_CTRL_WMASK;
      else
        ctrl_q[1:0] <= mode_d;
      if (wr_time)
        time_q <= reg_wdata;
      if (reg_addr == `PEWC_OFS_CTRL)
        reg_rdata_q <= {ctrl_q[15:6], flags_q, ctrl_q[1:0]};
      else if (reg_addr == `PEWC_OFS_TIME)
        reg_rdata_q <= time_q;
      else
        reg_rdata_q <= 16'h0000;
      // polarity applied to gated hit
      power_event_output_q <= (pme_hit && !hold) ~^ ctrl_q[`PEWC_BIT_POL];
      mode_q <= ctrl_q[1:0];
      low_power_q <= st_q == ST_LOW && edet;
      traffic_en_q <= !(st_q == ST_LOW && edet);
      isr_energy_set_q <= energy_wake;
      isr_link_set_q <= evt_link_up;
    end
  end
endmodule // pewc_top

// ---- test/pewc_line_model.sv ----
`timescale 1ns/10ps
// registered line-side event detectors
module pewc_line_model (
  input wire logic mclk,
  input wire logic [3:0] req,
  output logic [3:0] evt = 4'h0
);
  always @(posedge mclk) evt <= req;
endmodule // pewc_line_model

// ---- test/pewc_chk.sv ----
`timescale 1ns/10ps
module pewc_chk (
  input wire logic mclk, resetn, reg_wr, reg_rd, line_energy, evt_link_up,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata_q,
  input wire logic [1:0] mode_q,
  input wire logic low_power_q, traffic_en_q, isr_energy_set_q, isr_link_set_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_mode_write: assert property (
    reg_wr && reg_addr == 8'hD4 && reg_wdata[1:0] != 2'h2
    |=> ##1 mode_q == $past(reg_wdata[1:0], 2)) else $error("mode field not written");
  chk_rdata_idle: assert property (
    reg_addr != 8'hD4 && reg_addr != 8'hD6
    |=> reg_rdata_q == 16'h0) else $error("read data not zero");
  chk_traffic_on: assert property (
    traffic_en_q == !low_power_q) else $error("traffic enable wrong");
  chk_lp_mode: assert property (
    low_power_q |-> mode_q == 2'h1 || $changed(mode_q))
    else $error("low power outside energy detect");
  chk_host_wake: assert property (
    low_power_q && (reg_wr || reg_rd)
    |-> ##[1:2] !low_power_q) else $error("no wake on access");
  chk_link_isr: assert property (
    $rose(evt_link_up) |-> ##[1:2] isr_link_set_q) else $error("no link status pulse");
  chk_isr_pulse: assert property (
    isr_energy_set_q |=> !isr_energy_set_q) else $error("energy pulse too long");
  chk_energy_cause: assert property (
    isr_energy_set_q |-> $past(line_energy)) else $error("energy pulse without energy");
  cover property (low_power_q);
  cover property (isr_energy_set_q);
  cover property (isr_link_set_q);
endmodule // pewc_chk
bind pewc_top pewc_chk pewc_chk_inst (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .line_energy(line_energy), .evt_link_up(evt_link_up),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .mode_q(mode_q),
  .low_power_q(low_power_q), .traffic_en_q(traffic_en_q),
  .isr_energy_set_q(isr_energy_set_q), .isr_link_set_q(isr_link_set_q));

// ---- test/pewc_top_tb.sv ----
`timescale 1ns/10ps
module pewc_top_tb;
  logic mclk = 0, resetn = 0, por_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [3:0] req = 4'h0;
  logic [3:0] evt;
  wire [15:0] rdq;
  wire [1:0] mode;
  wire pin, lp, te;
  logic clocks_ready = 1;
  int err_total = 0, n_compared = 0;
  initial forever #50 mclk = ~mclk;
  pewc_line_model pewc_line_model_inst (.mclk(mclk), .req(req), .evt(evt));
  pewc_top #(.WAKE_UNIT_CYC(4), .SLEEP_UNIT_CYC(8)) pewc_top_inst (.mclk(mclk),
    .resetn(resetn), .por_n(por_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(rdq), .line_energy(evt[0]), .evt_link_up(evt[1]),
    .evt_wake_packet(evt[2]), .evt_wake_frame(evt[3]), .clocks_ready(clocks_ready),
    .power_event_output_q(pin), .mode_q(mode), .low_power_q(lp), .traffic_en_q(te),
    .isr_energy_set_q(), .isr_link_set_q());
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 0;
    #1 chk(rdq, e);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task ev(input logic [3:0] v);
    @(posedge mclk) req <= v;
  endtask
  task t_reset;
    rd(8'hD4, 16'h0000);
    rd(8'hD6, 16'h080C);
    chk(pin, 16'h1);
  endtask
  task t_pin;
    wr(8'hD4, 16'h1200);
    wait_n(3);
    chk(pin, 16'h0);
    ev(4'h2);
    ev(4'h0);
    wait_n(3);
    chk(pin, 16'h1);
    rd(8'hD4, 16'h1208);
    wr(8'hD4, 16'h1208);
    wait_n(3);
    chk(pin, 16'h0);
  endtask
  task t_keep;
    ev(4'h2);
    ev(4'h0);
    @(posedge mclk) resetn <= 0;
    @(posedge mclk) resetn <= 1;
    rd(8'hD4, 16'h0008);
    chk(pin, 16'h1);
    wr(8'hD4, 16'h003C);
  endtask
  task t_delay;
    wr(8'hD4, 16'h5280);
    @(posedge mclk) clocks_ready <= 0;
    ev(4'h2);
    ev(4'h0);
    wait_n(3);
    chk(pin, 16'h0);
    @(posedge mclk) clocks_ready <= 1;
    wait_n(3);
    chk(pin, 16'h1);
    wr(8'hD4, 16'h5208);
    @(posedge mclk) clocks_ready <= 0;
    ev(4'h2);
    ev(4'h0);
    wait_n(3);
    chk(pin, 16'h1);
    wr(8'hD4, 16'h0008);
    @(posedge mclk) clocks_ready <= 1;
  endtask
  task t_event;
    wr(8'hD4, 16'h1400);
    ev(4'h8);
    ev(4'h0);
    wait_n(3);
    chk(pin, 16'h0);
    rd(8'hD4, 16'h1420);
    ev(4'h4);
    ev(4'h0);
    wait_n(3);
    chk(pin, 16'h1);
    rd(8'hD4, 16'h1430);
    wr(8'hD4, 16'h0030);
    wait_n(3);
    chk(pin, 16'h1);
  endtask
  task t_wake;
    wr(8'hD4, 16'h00C1);
    wait_n(120);
    chk(lp, 16'h1);
    chk(te, 16'h0);
    rd(8'hD6, 16'h080C);
    wait_n(2);
    chk(lp, 16'h0);
    chk(te, 16'h1);
    wait_n(120);
    ev(4'h1);
    wait_n(50);
    chk(lp, 16'h0);
    chk(mode, 16'h0);
    ev(4'h0);
    rd(8'hD4, 16'h00C4);
  endtask
  task give_verdict;
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    {resetn, por_n} <= 2'h3;
    t_reset;
    t_pin;
    t_keep;
    t_delay;
    t_event;
    t_wake;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    give_verdict;
  end
endmodule // pewc_top_tb
